// ===== logic/cal_regs_pkg.sv
// Purpose: constants for the channel 2 configuration and calibration register slice
// Assumes: 16-bit registers addressed by word index
// Notes: offsets are word indices of the register map
package cal_regs_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] CHAN2_CFG_ADDR = 6'h13;
   localparam logic [ADDR_W-1:0] OCAL_HIGH_ADDR = 6'h14;
   localparam logic [ADDR_W-1:0] OCAL_LOW_ADDR = 6'h15;
   localparam logic [ADDR_W-1:0] GCAL_HIGH_ADDR = 6'h16;
   localparam logic [ADDR_W-1:0] GCAL_LOW_ADDR = 6'h17;
   localparam logic [ADDR_W-1:0] CHECKSUM_ADDR = 6'h3e;
   localparam logic [ADDR_W-1:0] SPARE_ADDR = 6'h3f;
   localparam int PHASE_MSB = 15;
   localparam int PHASE_LSB = 6;
   localparam int HPOFF_BIT = 2;
   localparam int MUX_MSB = 1;
   localparam int MUX_LSB = 0;
   localparam int LOWBYTE_MSB = 15;
   localparam int LOWBYTE_LSB = 8;
   localparam logic [DATA_W-1:0] ZERO_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] GAIN_HIGH_RESET = 16'h8000;
   localparam logic [1:0] MUX_PINS = 2'h0;
   localparam logic [1:0] MUX_SHORT = 2'h1;
   localparam logic [1:0] MUX_POS_TEST = 2'h2;
   localparam logic [1:0] MUX_NEG_TEST = 2'h3;
endpackage : cal_regs_pkg

// ===== logic/channel_cal_config_regs.sv
// What this block does
// R1: config bits 15:6 hold signed ten-bit phase delay, reset zero.
// R2: config bits 5:3 are reserved, read-only, always read 000b.
// R3: config bit 2 set disables high-pass filter; clear defers to global corner.
// R4: config bits 1:0 select pins, shorted, positive or negative test signal.
// R5: offset high word holds offset bits 23:8, read/write, reset zero.
// R6: offset low upper byte holds offset bits 7:0; lower byte reads zero.
// R7: gain high word holds gain bits 23:8, resets to 8000h for unity.
// R8: gain low upper byte holds gain bits 7:0; lower byte reads zero.
// R9: checksum word at 3Eh is read-only, reads checksum_value input with no reset of its own, writes ignored.
// R10: host writes only zeros to spare word at 3Fh, reset zero.
//
// Purpose: channel 2 configuration and calibration register slice
// Assumes: serial front end delivers decoded word accesses synchronous to mclk
// Notes: read data is registered, valid the cycle after rd_en
`timescale 1ns/1ps
`default_nettype none
module channel_cal_config_regs
   import cal_regs_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic [DATA_W-1:0] checksum_value,
   output logic [DATA_W-1:0] rd_data,
   output logic rd_valid,
   output logic [9:0] chan2_phase_delay,
   output logic chan2_hp_filter_off,
   output logic [1:0] chan2_input_select,
   output logic [23:0] chan2_offset_cal,
   output logic [23:0] chan2_gain_cal
);
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [DATA_W-1:0] CFG_MASK = 16'hffc7;
   localparam logic [DATA_W-1:0] LOW_MASK = 16'hff00;
   localparam logic [DATA_W-1:0] FULL_MASK = 16'hffff;
   localparam int NWORDS = 6;

   logic [DATA_W-1:0] word_val [NWORDS];
   logic [NWORDS-1:0] wr_hit;

   ////////////////////////////////////////////////////////////////////////////
   // write decode; checksum and unmapped words have no storage, so writes fall away
   always_comb begin
      wr_hit = {NWORDS{1'b0}};
      if (wr_en) begin
         case (addr)
            CHAN2_CFG_ADDR: begin
               wr_hit[0] = 1'b1;
            end
            OCAL_HIGH_ADDR: begin
               wr_hit[1] = 1'b1;
            end
            OCAL_LOW_ADDR: begin
               wr_hit[2] = 1'b1;
            end
            GCAL_HIGH_ADDR: begin
               wr_hit[3] = 1'b1;
            end
            GCAL_LOW_ADDR: begin
               wr_hit[4] = 1'b1;
            end
            SPARE_ADDR: begin
               wr_hit[5] = 1'b1;
            end
            default: begin
               wr_hit = {NWORDS{1'b0}}; // R9
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // storage words; masks keep reserved bits at zero
   genvar g;
   generate
      for (g = 0; g < NWORDS; g++) begin : g_word
         localparam logic [DATA_W-1:0] RV = (g == 3) ? GAIN_HIGH_RESET : ZERO_RESET; // R7
         localparam logic [DATA_W-1:0] WM = (g == 0) ? CFG_MASK : // R2
                                            ((g == 2) || (g == 4)) ? LOW_MASK : // R6 R8
                                            FULL_MASK; // R5 R7
         // spare word stores what is written; host is expected to write zero
         reg_word #(.RESET_VAL(RV), .WMASK(WM)) u_word (
            .mclk(mclk),
            .reset(reset),
            .wr_en(wr_hit[g]), // R10
            .wr_data(wr_data),
            .value(word_val[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // field outputs
   assign chan2_phase_delay = word_val[0][PHASE_MSB:PHASE_LSB]; // R1
   assign chan2_hp_filter_off = word_val[0][HPOFF_BIT]; // R3
   assign chan2_input_select = word_val[0][MUX_MSB:MUX_LSB]; // R4
   assign chan2_offset_cal = {word_val[1], word_val[2][LOWBYTE_MSB:LOWBYTE_LSB]}; // R5 R6
   assign chan2_gain_cal = {word_val[3], word_val[4][LOWBYTE_MSB:LOWBYTE_LSB]}; // R7 R8

   ////////////////////////////////////////////////////////////////////////////
   // read path; checksum comes from the map checksum engine, never written here
   logic [DATA_W-1:0] rd_data_q;
   logic [DATA_W-1:0] rd_data_d;
   logic rd_valid_q;
   logic rd_valid_d;

   always_comb begin
      rd_data_d = rd_data_q;
      rd_valid_d = rd_en;
      if (rd_en) begin
         case (addr)
            CHAN2_CFG_ADDR: begin
               rd_data_d = word_val[0] & CFG_MASK; // R2
            end
            OCAL_HIGH_ADDR: begin
               rd_data_d = word_val[1]; // R5
            end
            OCAL_LOW_ADDR: begin
               rd_data_d = word_val[2] & LOW_MASK; // R6
            end
            GCAL_HIGH_ADDR: begin
               rd_data_d = word_val[3]; // R7
            end
            GCAL_LOW_ADDR: begin
               rd_data_d = word_val[4] & LOW_MASK; // R8
            end
            CHECKSUM_ADDR: begin
               rd_data_d = checksum_value; // R9
            end
            SPARE_ADDR: begin
               rd_data_d = word_val[5];
            end
            default: begin
               rd_data_d = ZERO_RESET; // unmapped words read zero but still answer
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         rd_data_q <= ZERO_RESET;
         rd_valid_q <= 1'b0;
      end else begin
         rd_data_q <= rd_data_d;
         rd_valid_q <= rd_valid_d;
      end
   end

   assign rd_data = rd_data_q;
   assign rd_valid = rd_valid_q;
endmodule : channel_cal_config_regs
`default_nettype wire

// ===== logic/reg_word.sv
// Purpose: one 16-bit storage word with per-bit write mask and reset value
// Assumes: synchronous active-high reset
// Notes: bits outside the mask stay at zero and read as zero
`timescale 1ns/1ps
`default_nettype none
module reg_word #(
   parameter logic [15:0] RESET_VAL = 16'h0000,
   parameter logic [15:0] WMASK = 16'hffff
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic wr_en,
   input wire logic [15:0] wr_data,
   output logic [15:0] value
);
   logic [15:0] value_q;
   logic [15:0] value_d;

   always_comb begin
      value_d = value_q;
      if (wr_en) begin
         value_d = wr_data & WMASK;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         value_q <= RESET_VAL & WMASK;
      end else begin
         value_q <= value_d;
      end
   end

   assign value = value_q;
endmodule : reg_word
`default_nettype wire

// ===== verif/regs_monitor.sv
// Purpose: checker for the channel 2 slice
// Assumes: top module ports only
// Notes: bind at foot
`timescale 1ns/1ps
`default_nettype none
module regs_monitor
   import cal_regs_pkg::*;
(
   input wire logic mclk, reset, wr_en, rd_en, chan2_hp_filter_off, rd_valid,
   input wire logic [5:0] addr,
   input wire logic [15:0] wr_data, checksum_value, rd_data,
   input wire logic [9:0] chan2_phase_delay,
   input wire logic [1:0] chan2_input_select,
   input wire logic [23:0] chan2_offset_cal, chan2_gain_cal
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   wire logic wc = wr_en && addr == CHAN2_CFG_ADDR;
   property p_ph; wc |=> chan2_phase_delay == $past(wr_data[15:6]); endproperty
   a_ph: assert property (p_ph) else $error("phase");
   property p_rs; rd_en && addr == CHAN2_CFG_ADDR |=> rd_data[5:3] == 3'h0; endproperty
   a_rs: assert property (p_rs) else $error("rsvd");
   property p_hp; wc |=> chan2_hp_filter_off == $past(wr_data[2]); endproperty
   a_hp: assert property (p_hp) else $error("filter");
   property p_mx; wc |=> chan2_input_select == $past(wr_data[1:0]); endproperty
   a_mx: assert property (p_mx) else $error("mux");
   property p_oh; wr_en && addr == OCAL_HIGH_ADDR |=> chan2_offset_cal[23:8] == $past(wr_data); endproperty
   a_oh: assert property (p_oh) else $error("ofs");
   // old byte: a same-cycle write lands after the read
   property p_ol; rd_en && addr == OCAL_LOW_ADDR |=> rd_data == {$past(chan2_offset_cal[7:0]), 8'h00}; endproperty
   a_ol: assert property (p_ol) else $error("ofs low");
   property p_gr; $fell(reset) |-> chan2_gain_cal == 24'h800000; endproperty
   a_gr: assert property (p_gr) else $error("gain");
   property p_ck; rd_en && addr == CHECKSUM_ADDR |=> rd_data == $past(checksum_value); endproperty
   a_ck: assert property (p_ck) else $error("crc");
   property p_rv; rd_valid == $past(rd_en); endproperty
   a_rv: assert property (p_rv) else $error("read valid");
   c_ck: cover property (rd_en && addr == CHECKSUM_ADDR);
   c_wc: cover property (wc);
   c_rd: cover property (rd_en);
   c_wr: cover property (wr_en);
endmodule : regs_monitor
////////////////////
bind channel_cal_config_regs regs_monitor regs_monitor_i (.*);
`default_nettype wire

// ===== verif/test_channel_cal_config_regs.sv
// Purpose: slice bench
// Assumes: 200 MHz mclk
// Notes: directed only
`timescale 1ns/1ps
`default_nettype none
module test_channel_cal_config_regs;
   import cal_regs_pkg::*;
   logic mclk = 1'b0, reset = 1'b1, wr_en = 1'b0, rd_en = 1'b0, rd_valid, chan2_hp_filter_off;
   logic [5:0] addr = 6'h00;
   logic [15:0] wr_data = 16'h0000, checksum_value = 16'h0000, rd_data;
   logic [9:0] chan2_phase_delay;
   logic [1:0] chan2_input_select;
   logic [23:0] chan2_offset_cal, chan2_gain_cal;
   int n_errors = 0, checks_done = 0;
   channel_cal_config_regs channel_cal_config_regs_i (.*);
   always #2.5 mclk = ~mclk;
   ////////////////////
   task final_report;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   task cmp_field(string name, logic [23:0] exp, logic [23:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s exp %h got %h", name, exp, got);
      end
   endtask : cmp_field
   // reads compare with x; rd_valid is fixed one cycle late, so no wait loop
   task acc(logic w, logic [5:0] a, logic [15:0] x);
      @(posedge mclk);
      {wr_en, rd_en, addr, wr_data} <= {w, !w, a, x};
      @(posedge mclk);
      {wr_en, rd_en} <= 2'h0;
      #1;
      checks_done += !w;
      if (!w && {rd_valid, rd_data} !== {1'b1, x}) begin
         n_errors++;
         $display("wrong value rd_data at %h exp %h got %h valid %b", a, x, rd_data, rd_valid);
      end
   endtask : acc
   task t_cfg;
      logic [15:0] v;
      for (int m = 0; m < 4; m++) begin
         v = 16'(m * 16'h4045);
         acc(1'b1, CHAN2_CFG_ADDR, 16'(m * 16'h4045) | 16'h0038);
         cmp_field("chan2_phase_delay", 24'(v[15:6]), 24'(chan2_phase_delay));
         cmp_field("chan2_hp_filter_off", 24'(v[2]), 24'(chan2_hp_filter_off));
         cmp_field("chan2_input_select", 24'(v[1:0]), 24'(chan2_input_select));
         acc(1'b0, CHAN2_CFG_ADDR, 16'(m * 16'h4045) & 16'hffc7);
      end
   endtask : t_cfg
   task t_cal;
      acc(1'b0, GCAL_HIGH_ADDR, GAIN_HIGH_RESET);
      acc(1'b1, OCAL_HIGH_ADDR, 16'ha5c3);
      acc(1'b1, OCAL_LOW_ADDR, 16'h5aff);
      acc(1'b0, OCAL_LOW_ADDR, 16'h5a00);
      acc(1'b1, GCAL_LOW_ADDR, 16'h56ff);
      acc(1'b0, GCAL_LOW_ADDR, 16'h5600);
      cmp_field("chan2_offset_cal", 24'ha5c35a, chan2_offset_cal);
      cmp_field("chan2_gain_cal", 24'h800056, chan2_gain_cal);
   endtask : t_cal
   task t_reset;
      @(posedge mclk) reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      #1;
      cmp_field("rd_valid", 24'h000000, 24'(rd_valid));
      cmp_field("chan2_phase_delay", 24'h000000, 24'(chan2_phase_delay));
      cmp_field("chan2_offset_cal", 24'h000000, chan2_offset_cal);
      cmp_field("chan2_gain_cal", 24'h800000, chan2_gain_cal);
      acc(1'b0, GCAL_HIGH_ADDR, GAIN_HIGH_RESET);
   endtask : t_reset
   task t_misc;
      @(posedge mclk) checksum_value <= 16'hbeef;
      acc(1'b1, CHECKSUM_ADDR, 16'hffff);
      acc(1'b0, CHECKSUM_ADDR, 16'hbeef);
      acc(1'b1, SPARE_ADDR, 16'h0000);
      acc(1'b0, SPARE_ADDR, 16'h0000);
      acc(1'b0, 6'h20, 16'h0000);
   endtask : t_misc
   initial begin
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      t_cal();
      t_cfg();
      t_misc();
      t_reset();
      final_report();
   end
endmodule : test_channel_cal_config_regs
`default_nettype wire
